/* hdl/sync_sram_defs.vh */
`ifndef SYNC_SRAM_DEFS_VH
`define SYNC_SRAM_DEFS_VH

`define ADDR_WIDTH      15
`define DATA_WIDTH      32
`define LANE_COUNT      4
`define LANE_WIDTH      8
`define BURST_BITS      2
`define POWER_UP_MS     1
`define CLOCK_KHZ       25000
`define POWER_UP_CYCLES (`POWER_UP_MS * `CLOCK_KHZ)

`endif

/* hdl/sram_storage.v */
`timescale 1ns/1ns
`default_nettype none
module sram_storage #(
  parameter ADDR_WIDTH = 15,
  parameter LANE_COUNT = 4,
  parameter LANE_WIDTH = 8
) (
  input  wire                           i_clock,   // core clock
  input  wire [ADDR_WIDTH-1:0]          i_addr,    // word address
  input  wire [LANE_COUNT-1:0]          i_lane_we, // per-lane write strobe
  input  wire [LANE_COUNT*LANE_WIDTH-1:0] i_wdata, // write data
  output reg  [LANE_COUNT*LANE_WIDTH-1:0] o_rdata  // registered read data
);
  reg [LANE_COUNT*LANE_WIDTH-1:0] cells [0:(1<<ADDR_WIDTH)-1];
  integer lane;

  always @(posedge i_clock) begin
    for (lane = 0; lane < LANE_COUNT; lane = lane + 1) begin
      if (i_lane_we[lane]) begin
        cells[i_addr][lane*LANE_WIDTH +: LANE_WIDTH] <= i_wdata[lane*LANE_WIDTH +: LANE_WIDTH];
      end
    end
    o_rdata <= cells[i_addr];
  end
endmodule
`default_nettype wire

/* hdl/sync_sram_select_write_sleep.v */
// Operation
// - selected only when pipelined select low, depth high, depth-low select low
// - all lanes written on global write low, or gate low with all lanes low
// - after a write, data bus stays high-Z until a strobe or burst step
// - data pins are high-Z on leaving sleep, never stale data
`timescale 1ns/1ns
`default_nettype none
`include "sync_sram_defs.vh"
module sync_sram_select_write_sleep #(
  parameter ADDR_WIDTH = `ADDR_WIDTH,
  parameter DATA_WIDTH = `DATA_WIDTH,
  parameter LANE_COUNT = `LANE_COUNT,
  parameter LANE_WIDTH = `LANE_WIDTH
) (
  input  wire                  i_clock,               // 25 MHz clock
  input  wire                  i_rstn,                // async reset, active low
  input  wire [ADDR_WIDTH-1:0] i_addr,                // address
  input  wire                  i_select_pipelined_n,  // chip enable, active low
  input  wire                  i_select_depth_high,   // chip enable, active high
  input  wire                  i_select_depth_low_n,  // chip enable, active low
  input  wire                  i_cpu_addr_strobe_n,   // processor address strobe
  input  wire                  i_ctrl_addr_strobe_n,  // controller address strobe
  input  wire                  i_burst_step_n,        // burst advance
  input  wire                  i_all_bytes_write_n,   // global write
  input  wire                  i_lane_write_gate_n,   // byte write enable
  input  wire [LANE_COUNT-1:0] i_lane_write_n,        // per-lane write controls
  input  wire                  i_output_enable_n,     // output enable
  input  wire                  i_sleep_request,       // sleep request
  input  wire [DATA_WIDTH-1:0] i_dq,                  // data pins in
  output reg  [DATA_WIDTH-1:0] o_dq,                  // data pins out
  output wire                  o_dq_oe,               // data pins drive enable
  output reg                   o_selected,            // latched composite select
  output reg                   o_asleep               // sleep mode status
);
  ////////////////////////////////////////////////////////////////////////////////
  // reset release
  reg rst_meta;
  reg rst_sync;
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  wire select_now = !i_select_pipelined_n && i_select_depth_high && !i_select_depth_low_n;
  wire strobe_cpu = !i_cpu_addr_strobe_n && !i_sleep_request;
  wire strobe_ctl = !i_ctrl_addr_strobe_n && !i_sleep_request;
  // processor strobe is ignored while pipelined select is high
  wire load_cpu   = strobe_cpu && !i_select_pipelined_n;
  wire load_addr  = load_cpu || strobe_ctl;
  wire step_burst = i_ctrl_addr_strobe_n && (i_cpu_addr_strobe_n || i_select_pipelined_n)
                    && !i_burst_step_n && !i_sleep_request;
  wire full_write = !i_all_bytes_write_n ||
                    (!i_lane_write_gate_n && (i_lane_write_n == {LANE_COUNT{1'b0}}));
  wire [LANE_COUNT-1:0] lane_req =
    full_write ? {LANE_COUNT{1'b1}} :
    (!i_lane_write_gate_n ? ~i_lane_write_n : {LANE_COUNT{1'b0}});
  // write controls are ignored on a processor strobe cycle
  wire write_cycle = !load_cpu && (lane_req != {LANE_COUNT{1'b0}});

  ////////////////////////////////////////////////////////////////////////////////
  // address, burst and access state
  reg [ADDR_WIDTH-1:0] base_addr;
  reg [`BURST_BITS-1:0] burst_cnt;
  reg                   read_pend;
  reg                   read_valid;
  reg                   hold_hiz;
  wire [ADDR_WIDTH-1:0] cur_addr = {base_addr[ADDR_WIDTH-1:`BURST_BITS],
                                    base_addr[`BURST_BITS-1:0] + burst_cnt};
  wire [ADDR_WIDTH-1:0] mem_addr = load_addr ? i_addr : cur_addr;
  wire access = (load_addr && select_now) || (step_burst && o_selected);
  wire [LANE_COUNT-1:0] lane_we = (access && write_cycle) ? lane_req : {LANE_COUNT{1'b0}};
  wire [DATA_WIDTH-1:0] rdata;

  always @(posedge i_clock or negedge rst_sync) begin
    if (!rst_sync) begin
      base_addr  <= {ADDR_WIDTH{1'b0}};
      burst_cnt  <= {`BURST_BITS{1'b0}};
      o_selected <= 1'b0;
      read_pend  <= 1'b0;
      read_valid <= 1'b0;
      hold_hiz   <= 1'b1;
      o_asleep   <= 1'b0;
      o_dq       <= {DATA_WIDTH{1'b0}};
    end else begin
      o_asleep <= i_sleep_request;
      if (load_addr) begin
        base_addr  <= i_addr;
        burst_cnt  <= {`BURST_BITS{1'b0}};
        o_selected <= select_now;
      end else if (step_burst) begin
        burst_cnt <= burst_cnt + 1'b1;
      end
      read_pend  <= access && !write_cycle;
      read_valid <= read_pend && !i_sleep_request;
      if (read_pend) begin
        o_dq <= rdata;
      end
      if (i_sleep_request || o_asleep) begin
        hold_hiz   <= 1'b1;
        read_valid <= 1'b0;
      end else if (access && write_cycle) begin
        hold_hiz <= 1'b1;
      end else if (load_addr || step_burst) begin
        hold_hiz <= 1'b0;
      end
    end
  end

  assign o_dq_oe = read_valid && !hold_hiz && !i_output_enable_n && !o_asleep;

  ////////////////////////////////////////////////////////////////////////////////
  // storage
  sram_storage #(
    .ADDR_WIDTH (ADDR_WIDTH),
    .LANE_COUNT (LANE_COUNT),
    .LANE_WIDTH (LANE_WIDTH)
  ) u_storage (
    .i_clock   (i_clock),
    .i_addr    (mem_addr),
    .i_lane_we (lane_we),
    .i_wdata   (i_dq),
    .o_rdata   (rdata)
  );
endmodule
`default_nettype wire

/* test/sram_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module sram_chk (
  input wire logic i_clock,              // clk
  input wire logic i_rstn,               // rst
  input wire logic i_select_pipelined_n, // en
  input wire logic i_select_depth_high,  // en
  input wire logic i_select_depth_low_n, // en
  input wire logic i_ctrl_addr_strobe_n, // stb
  input wire logic i_all_bytes_write_n,  // wr
  input wire logic i_lane_write_gate_n,  // wr
  input wire logic [3:0] i_lane_write_n, // lanes
  input wire logic i_sleep_request,      // slp
  input wire logic o_dq_oe               // oe
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  wire hit = !i_select_pipelined_n && i_select_depth_high && !i_select_depth_low_n;
  wire take = !i_ctrl_addr_strobe_n && !i_sleep_request;
  wire wr = !i_all_bytes_write_n || (!i_lane_write_gate_n && i_lane_write_n != 4'hf);
  chk_read_drive: assert property (take && hit && !wr |-> ##2 o_dq_oe) else $error("no oe");
  chk_desel_quiet: assert property (take && !hit |-> ##2 !o_dq_oe) else $error("desel oe");
  chk_write_quiet: assert property (take && hit && wr |=> (!o_dq_oe)[*3]) else $error("wr oe");
  chk_sleep_quiet: assert property (i_sleep_request |=> !o_dq_oe) else $error("sleep oe");
  chk_wake_quiet: assert property ($fell(i_sleep_request) |-> !o_dq_oe ##1 !o_dq_oe)
    else $error("wake oe");
  cover property (take && hit && wr);
  cover property (take && !hit);
  cover property ($fell(i_sleep_request));
endmodule
bind sync_sram_select_write_sleep sram_chk u_chk (.*);
`default_nettype wire

/* test/ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sync_sram_defs.vh"
module ctrl_model (
  input  wire logic   i_clock, // clk
  output logic [2:0]  o_ce,    // en
  output logic [1:0]  o_wr,    // wr
  output logic [3:0]  o_ln,    // lanes
  output logic        o_stb_n, // stb
  output logic        o_sleep, // slp
  output logic [14:0] o_addr,  // addr
  output logic [31:0] o_dq     // data
);
  logic up = 1'b0;
  task automatic idle();
    {o_ce, o_wr, o_ln, o_stb_n} = 10'h27f;
    o_dq = ~o_dq;
  endtask
  task automatic op(input [2:0] c, input [1:0] w, input [3:0] l, input [14:0] a, input [31:0] d);
    wait (up);
    @(negedge i_clock);
    {o_ce, o_wr, o_ln, o_stb_n, o_addr, o_dq} = {c, w, l, 1'b0, a, d};
    repeat (4) begin
      @(negedge i_clock);
      idle();
    end
  endtask
  task automatic doze(input on);
    @(negedge i_clock);
    o_sleep = on;
  endtask
  initial begin
    {o_sleep, o_addr, o_dq} = 48'h0;
    idle();
    repeat (`POWER_UP_CYCLES) @(negedge i_clock);
    up = 1'b1;
  end
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sync_sram_defs.vh"
module tb;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic [31:0] rnd = 32'h3c;
  logic [31:0] mem [8];
  logic [31:0] q [$];
  int n_mismatch = 0;
  int total_checks = 0;
  wire [2:0] ce;
  wire [1:0] wr;
  wire [3:0] ln;
  wire stb_n, slp, o_dq_oe, sel, asl;
  logic adv_n = 1'b1;
  wire [14:0] addr;
  wire [31:0] dq_in, o_dq;
  always #20 i_clock = ~i_clock;
  ctrl_model u_ctl (.i_clock(i_clock), .o_ce(ce), .o_wr(wr), .o_ln(ln), .o_stb_n(stb_n),
    .o_sleep(slp), .o_addr(addr), .o_dq(dq_in));
  sync_sram_select_write_sleep DUT (.i_clock(i_clock), .i_rstn(i_rstn), .i_addr(addr),
    .i_select_pipelined_n(ce[2]), .i_select_depth_high(ce[1]), .i_select_depth_low_n(ce[0]),
    .i_cpu_addr_strobe_n(1'b1), .i_ctrl_addr_strobe_n(stb_n), .i_burst_step_n(adv_n),
    .i_all_bytes_write_n(wr[1]), .i_lane_write_gate_n(wr[0]), .i_lane_write_n(ln),
    .i_output_enable_n(1'b0), .i_sleep_request(slp), .i_dq(dq_in), .o_dq(o_dq),
    .o_dq_oe(o_dq_oe), .o_selected(sel), .o_asleep(asl));
  function automatic [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string nm, input [31:0] seen, input [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic acc(input [2:0] c, input [1:0] w, input [3:0] l, input [2:0] a);
    rnd = nxt(rnd);
    if (c == 3'h2 && !u_ctl.o_sleep && w == 2'h3) q.push_back(mem[a]);
    for (int i = 0; i < 4; i++)
      if (c == 3'h2 && !u_ctl.o_sleep && w != 2'h3 && (!w[1] || !l[i])) mem[a][8*i+:8] = rnd[8*i+:8];
    u_ctl.op(c, w, l, {12'h0, a}, rnd);
  endtask
  always @(negedge i_clock)
    if (o_dq_oe === 1'b1) begin
      if (q.size()) check("rdata", o_dq, q.pop_front());
      else check("spare_oe", 32'h1, 32'h0);
    end
  initial begin
    repeat (`POWER_UP_CYCLES + 4000) @(posedge i_clock);
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (8) @(negedge i_clock);
    i_rstn = 1'b1;
    for (int a = 0; a < 16; a++) acc(3'h2, {a >= 8, 1'b1}, 4'hf, a[2:0]);
    for (int c = 0; c < 8; c++) begin
      acc(c[2:0], 2'h0, 4'hf, 3'h3);
      check("selected", {31'h0, sel}, {31'h0, c == 2});
      acc(c[2:0], 2'h3, 4'hf, 3'h3);
      acc(3'h2, 2'h3, 4'hf, 3'h3);
    end
    for (int k = 0; k < 15; k++) begin
      acc(3'h2, 2'h2, k[3:0], 3'h5);
      acc(3'h2, 2'h3, k[3:0], 3'h5);
    end
    u_ctl.doze(1'b1);
    acc(3'h2, 2'h0, 4'hf, 3'h6);
    acc(3'h2, 2'h3, 4'hf, 3'h6);
    check("asleep", {31'h0, asl}, 32'h1);
    u_ctl.doze(1'b0);
    @(negedge i_clock);
    check("wake", {31'h0, o_dq_oe}, 32'h0);
    check("awake", {31'h0, asl}, 32'h0);
    acc(3'h2, 2'h3, 4'hf, 3'h5);
    acc(3'h2, 2'h0, 4'hf, 3'h4);
    q.push_back(mem[4]);
    adv_n = 1'b0;
    @(negedge i_clock);
    adv_n = 1'b1;
    repeat (4) @(negedge i_clock);
    check("queue", q.size(), 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
